// *** pkg/asef_pkg.sv ***
// Package for the angle, status and error flag register block
package asef_pkg;

    // ------------------------------------------------------------
    // Register offsets and layout
    // ------------------------------------------------------------
    localparam logic [7:0] ANGLE_WORD_OFFSET = 8'h20;
    localparam logic [7:0] CONDITION_OFFSET = 8'h22;
    localparam logic [7:0] FAULT_OFFSET = 8'h24;
    localparam logic [7:0] CONTROL_OFFSET = 8'h1E;
    localparam logic [3:0] CONDITION_TAG = 4'h8;
    localparam logic [3:0] FAULT_TAG = 4'hA;
    localparam int CLEAR_DONE_BIT = 10;
    localparam int CLEAR_FAULT_BIT = 8;
    localparam logic [11:0] FAULT_RESET_VALUE = 12'h001;
    localparam int FAULT_COUNT = 12;

    // ------------------------------------------------------------
    // Fault bit positions
    // ------------------------------------------------------------
    localparam int F_RESET_SEEN = 0;
    localparam int F_WEAK_FIELD = 1;
    localparam int F_ANALOG_UV = 2;
    localparam int F_SUPPLY_UV = 3;
    localparam int F_OSC = 4;
    localparam int F_MEMORY = 5;
    localparam int F_ZERO_CROSS = 6;
    localparam int F_LOCK_LOST = 7;
    localparam int F_QUADRATURE = 8;
    localparam int F_AVERAGING = 9;
    localparam int F_SELFTEST = 10;
    localparam int F_CAUTION = 11;

    // Fault detector inputs from the sensing logic
    typedef struct packed {
        logic caution_any;
        logic logic_selftest_fail;
        logic field_selftest_fail;
        logic averaging_rate_too_high;
        logic quadrature_output_bad;
        logic lock_lost;
        logic zero_crossing_timeout;
        logic memory_multi_bit;
        logic osc_high_watchdog;
        logic osc_low_watchdog;
        logic supply_undervoltage;
        logic analog_rail_undervoltage;
        logic weak_field;
    } asef_fault_in_type;

    // Device status inputs
    typedef struct packed {
        logic [1:0] chip_index;
        logic spin_direction;
        logic special_trigger;
        logic special_complete;
        logic boot_complete;
        logic logic_selftest_running;
        logic field_selftest_running;
        logic boot_in_progress;
        logic loop_locked;
        logic memory_loading;
        logic logic_selftest_reset;
    } asef_status_in_type;

    // All module state
    typedef struct packed {
        logic [11:0] fault;
        logic [11:0] fault_seen;
        logic special_done;
        logic boot_done;
        logic [1:0] chip_index;
        logic boot_prev;
        logic [15:0] rdata;
    } asef_state_type;

endpackage : asef_pkg

// *** verilog/asef_flags.sv ***
// Angle word, device condition and latched fault register block
// What this block does
// - Undervoltage bit is live OR of both detectors, gated by stored mask bits.
// - Parity bit makes the sixteen-bit angle word hold an odd count of ones.
// - Low twelve bits carry the tracking-loop angle, code times 360 over 4096.
// - Top four bits tag condition register 1000 and fault register 1010.
// - Two-bit chip index, captured at boot, shown for identification only.
// - Spin direction bit, 0 increasing, 1 decreasing, valid with hysteresis on.
// - Special-done clears on trigger, sets on completion, clears on clear-done write.
// - Boot-done sets after memory load and self-tests, holds until clear-done write or logic self-test reset.
// - Logic self-test running bit is high exactly while that test executes.
// - Field self-test running bit is high exactly while that test executes.
// - Boot-in-progress bit is high throughout the boot sequence.
// - Angle-valid bit is high only when locked and start-up has finished.
// - Fault flags latch high until cleared; host reads then clears them.
// - Caution summary bit sets on any unmasked caution, unless its mask is set.
// - Self-test failure bit sets when either self-test reports a failure.
// - Averaging error sets when averaging rate is too high for the speed.
// - Quadrature output fault sets when quadrature sequencing is lost.
// - Lock-lost fault sets when the tracking loop stops following the angle.
// - Zero-crossing fault sets when no crossing occurs within the expected time.
// - Memory uncorrectable fault sets on multi-bit error, checked only during load.
// - Oscillator fault sets when either oscillator watchdog trips.
// - Separate supply and analog undervoltage faults keep setting while present.
// - Reset-seen fault sets on power-on or hard reset, never on logic self-test.
// - Weak-field fault sets when field magnitude falls below the low threshold.
// - Fault-clear write clears only fault bits the host has already read.
// - Clear-done write clears both special-done and boot-done bits.
//
// Implementation choice: the strobed register port.
module asef_flags (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Sensing logic
    input wire logic [11:0] angle_code,
    input wire logic [12:0] fault_mask,
    input wire asef_pkg::asef_fault_in_type fault_in,
    input wire asef_pkg::asef_status_in_type status_in,
    // Live views
    output logic [15:0] shaft_position_word,
    output logic any_fault_summary
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    asef_pkg::asef_state_type state;
    asef_pkg::asef_state_type next_state;
    logic [11:0] fault_event;
    logic [11:0] clear_mask;
    logic undervoltage_live_flag;
    logic angle_valid;
    logic [15:0] condition_word;
    logic [15:0] fault_word;
    logic [14:0] angle_body;
    logic clear_fault;
    logic clear_done;
    logic boot_rise;

    // ------------------------------------------------------------
    // Live words
    // ------------------------------------------------------------
    always_comb begin
        undervoltage_live_flag = (fault_in.supply_undervoltage & ~fault_mask[asef_pkg::F_SUPPLY_UV])
            | (fault_in.analog_rail_undervoltage & ~fault_mask[asef_pkg::F_ANALOG_UV]);
        any_fault_summary = |(state.fault & ~fault_mask[11:0]);
        angle_body = {any_fault_summary, undervoltage_live_flag, 1'b0, angle_code};
        shaft_position_word = {1'b0, angle_body[14:13], ~(^angle_body), angle_code};
        angle_valid = status_in.loop_locked & state.boot_done & ~status_in.boot_in_progress;
        condition_word = {asef_pkg::CONDITION_TAG, 2'b00, state.chip_index,
            status_in.spin_direction, 1'b0, state.special_done, state.boot_done,
            status_in.logic_selftest_running,
            status_in.field_selftest_running,
            status_in.boot_in_progress,
            angle_valid};
        fault_word = {asef_pkg::FAULT_TAG, state.fault};
    end

    // ------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------
    always_comb begin
        fault_event = '0;
        fault_event[asef_pkg::F_CAUTION] = fault_in.caution_any & ~fault_mask[12];
        fault_event[asef_pkg::F_SELFTEST] = fault_in.logic_selftest_fail
            | fault_in.field_selftest_fail;
        fault_event[asef_pkg::F_AVERAGING] = fault_in.averaging_rate_too_high;
        fault_event[asef_pkg::F_QUADRATURE] = fault_in.quadrature_output_bad;
        fault_event[asef_pkg::F_LOCK_LOST] = fault_in.lock_lost;
        fault_event[asef_pkg::F_ZERO_CROSS] = fault_in.zero_crossing_timeout;
        fault_event[asef_pkg::F_MEMORY] = fault_in.memory_multi_bit
            & status_in.memory_loading;
        fault_event[asef_pkg::F_OSC] = fault_in.osc_high_watchdog
            | fault_in.osc_low_watchdog;
        fault_event[asef_pkg::F_SUPPLY_UV] = fault_in.supply_undervoltage;
        fault_event[asef_pkg::F_ANALOG_UV] = fault_in.analog_rail_undervoltage;
        fault_event[asef_pkg::F_WEAK_FIELD] = fault_in.weak_field;
        fault_event[asef_pkg::F_RESET_SEEN] = 1'b0;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        clear_fault = reg_wr && reg_addr == asef_pkg::CONTROL_OFFSET
            && reg_wdata[asef_pkg::CLEAR_FAULT_BIT];
        clear_done = reg_wr && reg_addr == asef_pkg::CONTROL_OFFSET
            && reg_wdata[asef_pkg::CLEAR_DONE_BIT];
        boot_rise = status_in.boot_complete & ~state.boot_prev;
        next_state.boot_prev = status_in.boot_complete;
        clear_mask = clear_fault ? state.fault_seen : '0;
        next_state.fault = (state.fault & ~clear_mask) | fault_event;
        if (clear_fault) begin
            next_state.fault_seen = '0;
        end
        if (reg_rd && reg_addr == asef_pkg::FAULT_OFFSET) begin
            next_state.fault_seen = state.fault_seen | (state.fault & ~clear_mask);
        end
        if (clear_done) begin
            next_state.special_done = 1'b0;
            next_state.boot_done = 1'b0;
        end
        if (status_in.special_trigger) begin
            next_state.special_done = 1'b0;
        end
        if (status_in.special_complete) begin
            next_state.special_done = 1'b1;
        end
        if (status_in.logic_selftest_reset) begin
            next_state.boot_done = 1'b0;
        end
        if (boot_rise) begin
            next_state.boot_done = 1'b1;
            next_state.chip_index = status_in.chip_index;
        end
        next_state.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                asef_pkg::ANGLE_WORD_OFFSET: next_state.rdata = shaft_position_word;
                asef_pkg::CONDITION_OFFSET: next_state.rdata = condition_word;
                asef_pkg::FAULT_OFFSET: next_state.rdata = fault_word;
                default: next_state.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
            state.fault <= asef_pkg::FAULT_RESET_VALUE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;

endmodule : asef_flags

// *** verif/asef_flags_properties.sv ***
// Checker for the flag register block
module asef_flags_properties (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [11:0] angle_code,
    input wire logic [12:0] fault_mask,
    input wire asef_pkg::asef_fault_in_type fault_in,
    input wire asef_pkg::asef_status_in_type status_in,
    input wire logic [15:0] shaft_position_word,
    input wire logic any_fault_summary
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    sequence rd_at(logic [7:0] a);
        reg_rd && clk_en && reg_addr == a;
    endsequence
    parity_odd_a: assert property (
        ^shaft_position_word) else $error("parity even");
    angle_bits_a: assert property (
        shaft_position_word[11:0] == angle_code) else $error("angle bits");
    uv_live_a: assert property (
        shaft_position_word[13] == (fault_in.supply_undervoltage & ~fault_mask[3]
        | fault_in.analog_rail_undervoltage & ~fault_mask[2])) else $error("uv");
    rd_idle_a: assert property (
        !$past(reg_rd) && $past(clk_en) |-> reg_rdata == 16'h0000) else $error("idle");
    cond_tag_a: assert property (
        rd_at(8'h22) |=> {reg_rdata[15:10], reg_rdata[6]} == 7'h40) else $error("cond");
    fault_tag_a: assert property (
        rd_at(8'h24) |=> reg_rdata[15:12] == 4'hA) else $error("fault tag");
    run_bits_a: assert property (
        rd_at(8'h22) |=> reg_rdata[3:2] == $past({status_in.logic_selftest_running,
        status_in.field_selftest_running})) else $error("running");
    angle_ok_a: assert property (
        rd_at(8'h22) |=> reg_rdata[0] == (reg_rdata[4] && $past(status_in.loop_locked
        && !status_in.boot_in_progress))) else $error("angle ok");
    lock_set_a: assert property (
        clk_en && fault_in.lock_lost && !fault_mask[7] |=> any_fault_summary)
        else $error("lock");
    cover property (rd_at(8'h22));
    cover property (rd_at(8'h24) ##1 reg_rdata[11:0] != 12'h000);
    cover property (any_fault_summary ##1 !any_fault_summary);
endmodule : asef_flags_properties
bind asef_flags asef_flags_properties u_asef_flags_properties (.mclk, .nrst, .clk_en,
    .reg_addr, .reg_rd, .reg_rdata, .angle_code, .fault_mask, .fault_in, .status_in,
    .shaft_position_word, .any_fault_summary);

// *** verif/asef_host.sv ***
// Host model on the register port
module asef_host (
    // Clock
    input wire logic mclk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge mclk);
        d = reg_rdata;
    endtask : rd_reg
endmodule : asef_host

// *** verif/asef_flags_test.sv ***
// Testbench for the flag register block
module asef_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
        $display("[ERR] %0t %h %h", $time, a, e); end end
    logic mclk, nrst, reg_wr, reg_rd, afs;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, spw;
    logic [11:0] angle_code = 12'h000;
    logic [12:0] fault_mask = 13'h0000;
    asef_pkg::asef_fault_in_type fi = '0;
    asef_pkg::asef_status_in_type st = '0;
    int failures = 0;
    int comparisons = 0;
    asef_flags u_asef_flags (.mclk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .angle_code, .fault_mask, .fault_in(fi), .status_in(st),
        .shaft_position_word(spw), .any_fault_summary(afs));
    asef_host u_asef_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_asef_host.rd_reg(a, d);
        `CHK(d, e)
    endtask : rd
    task automatic t_faults;
        int map[13] = '{1, 2, 3, 4, 4, 5, 6, 7, 8, 9, 10, 10, 11};
        st.memory_loading <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            @(posedge mclk);
            fi <= asef_pkg::asef_fault_in_type'(13'h0001 << i);
            @(posedge mclk);
            fi <= '0;
            rd(8'h24, 16'hA000 | 16'h0001 << map[i]);
            u_asef_host.wr_reg(8'h1E, 16'h0100);
        end
        st.memory_loading <= 1'b0;
        @(posedge mclk);
        fi <= asef_pkg::asef_fault_in_type'(13'h00A0);
        @(posedge mclk);
        fi <= '0;
        u_asef_host.wr_reg(8'h1E, 16'h0100);
        rd(8'h24, 16'hA080);
        u_asef_host.wr_reg(8'h1E, 16'h0100);
        rd(8'h24, 16'hA000);
    endtask : t_faults
    task automatic t_status;
        st <= '{chip_index: 2'h2, spin_direction: 1'b1, boot_complete: 1'b1,
            logic_selftest_running: 1'b1, loop_locked: 1'b1, default: 1'b0};
        rd(8'h22, 16'h8299);
        st.special_complete <= 1'b1;
        @(posedge mclk);
        st.special_complete <= 1'b0;
        rd(8'h22, 16'h82B9);
        st.special_trigger <= 1'b1;
        @(posedge mclk);
        st.special_trigger <= 1'b0;
        rd(8'h22, 16'h8299);
        u_asef_host.wr_reg(8'h1E, 16'h0400);
        st.field_selftest_running <= 1'b1;
        st.boot_in_progress <= 1'b1;
        rd(8'h22, 16'h828E);
    endtask : t_status
    task automatic t_angle;
        angle_code <= 12'hABC;
        fi.supply_undervoltage <= 1'b1;
        repeat (2) @(posedge mclk);
        `CHK(spw, 16'h6ABC)
        `CHK(afs, 1'b1)
        rd(8'h24, 16'hA008);
        u_asef_host.wr_reg(8'h1E, 16'h0100);
        rd(8'h24, 16'hA008);
        fault_mask <= 13'h0008;
        repeat (2) @(posedge mclk);
        `CHK(spw, 16'h0ABC)
        `CHK(afs, 1'b0)
    endtask : t_angle
    task automatic t_mask;
        fi.supply_undervoltage <= 1'b0;
        fault_mask <= 13'h1000;
        u_asef_host.wr_reg(8'h1E, 16'h0100);
        fi.caution_any <= 1'b1;
        @(posedge mclk);
        fi.caution_any <= 1'b0;
        fault_mask <= 13'h0000;
        rd(8'h24, 16'hA000);
        fi.lock_lost <= 1'b1;
        clk_en <= 1'b0;
        @(posedge mclk);
        fi.lock_lost <= 1'b0;
        clk_en <= 1'b1;
        @(posedge mclk);
        `CHK(afs, 1'b0)
        fi.lock_lost <= 1'b1;
        @(posedge mclk);
        fi.lock_lost <= 1'b0;
        @(posedge mclk);
        `CHK(afs, 1'b1)
    endtask : t_mask
    task automatic t_reset;
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd(8'h24, 16'hA001);
        rd(8'h22, 16'h829E);
        u_asef_host.wr_reg(8'h1E, 16'h0100);
        st.logic_selftest_reset <= 1'b1;
        @(posedge mclk);
        st.logic_selftest_reset <= 1'b0;
        rd(8'h24, 16'hA000);
        rd(8'h22, 16'h828E);
    endtask : t_reset
    task automatic wrap_up;
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        nrst = 1'b0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        rd(8'h24, 16'hA001);
        rd(8'h30, 16'h0000);
        u_asef_host.wr_reg(8'h1E, 16'h0100);
        rd(8'h24, 16'hA000);
        t_faults();
        t_status();
        t_angle();
        t_mask();
        t_reset();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        wrap_up();
    end
endmodule : asef_flags_test
